// ==== logic/mevp_pkg.sv ====
package mevp_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] MEVP_IDX_CTRL3 = 8'h5d;
    localparam logic [7:0] MEVP_IDX_INT_SRC = 8'h5e;
    localparam logic [7:0] MEVP_IDX_VECM_CFG = 8'h69;
    localparam logic [7:0] MEVP_IDX_VECM_THS_MSB = 8'h6a;
    localparam logic [7:0] MEVP_IDX_VECM_THS_LSB = 8'h6b;
    localparam logic [7:0] MEVP_IDX_VECM_CNT = 8'h6c;
    localparam logic [7:0] MEVP_IDX_OFF_X = 8'h70;
    localparam logic [7:0] MEVP_IDX_OFF_Y = 8'h71;
    localparam logic [7:0] MEVP_IDX_OFF_Z = 8'h72;
    localparam logic [7:0] MEVP_IDX_INIT_X = 8'h73;
    localparam logic [7:0] MEVP_IDX_INIT_Y = 8'h74;
    localparam logic [7:0] MEVP_IDX_INIT_Z = 8'h75;
    localparam logic [7:0] MEVP_IDX_STATUS = 8'h76;
    // Control three fields
    localparam int MEVP_RAW_BIT = 7;
    localparam int MEVP_OS_LSB = 4;
    localparam int MEVP_THS_UPD_BIT = 3;
    // Interrupt source fields
    localparam int MEVP_SRC_THS_BIT = 2;
    localparam int MEVP_SRC_VECM_BIT = 1;
    localparam int MEVP_SRC_DRDY_BIT = 0;
    // Vector-change config fields, then the debounce-mode bit of the threshold MSB register
    localparam int MEVP_ELE_BIT = 6;
    localparam int MEVP_INITM_BIT = 5;
    localparam int MEVP_UPDM_BIT = 4;
    localparam int MEVP_EN_BIT = 3;
    localparam int MEVP_DBCNTM_BIT = 7;
    localparam logic [7:0] MEVP_RESET_VALUE = 8'h00;
    // Rate codes, slowest first
    localparam logic [2:0] MEVP_RATE_1P56 = 3'h0;
    localparam logic [2:0] MEVP_RATE_800 = 3'h7;
    localparam logic [10:0] MEVP_RATIO_FLOOR = 11'h002;
    localparam logic [10:0] MEVP_RATIO_TOP = 11'h400;
endpackage : mevp_pkg

// ==== logic/mevp_postproc.sv ====
// The APB register port was decided locally.
`timescale 1ns/1ns
module mevp_postproc #(
    parameter int SW = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic signed [SW-1:0] raw_x,
    input wire logic signed [SW-1:0] raw_y,
    input wire logic signed [SW-1:0] raw_z,
    input wire logic [2:0] output_data_rate,
    input wire logic auto_sleep,
    input wire logic [2:0] wake_oversample_setting,
    input wire logic ths_event,
    input wire logic [2:0] ths_axis,
    output logic signed [SW-1:0] mag_x,
    output logic signed [SW-1:0] mag_y,
    output logic signed [SW-1:0] mag_z,
    output logic mag_valid,
    output logic [10:0] oversampling_ratio,
    output logic [2:0] ths_ref_load
);
    import mevp_pkg::*;

    logic [7:0] mag_control_three;
    logic [7:0] mag_interrupt_source;
    logic [7:0] mag_vector_change_config;
    logic [7:0] ths_msb;
    logic [7:0] ths_lsb;
    logic [7:0] vecm_cnt;
    logic signed [SW-1:0] off [3];
    logic signed [SW-1:0] init_ref [3];
    logic signed [SW-1:0] vref [3];
    logic signed [SW-1:0] next_out [3];
    logic signed [SW-1:0] raw [3];
    logic [7:0] dbc;
    logic vecm_live;
    logic en_d;
    logic src_read;
    logic wr_en;
    logic [9:0] idx;
    logic [2:0] sleep_oversample_setting;
    logic [2:0] os_sel;
    logic [14:0] vecm_ths;
    logic [2*SW+3:0] dist2;
    logic [31:0] ths2;
    logic over;
    logic vecm_fire;

    assign raw[0] = raw_x;
    assign raw[1] = raw_y;
    assign raw[2] = raw_z;
    assign idx = paddr[11:2];
    assign pready = 1'b1; // Zero-wait slave
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign src_read = psel && penable && !pwrite && idx == {2'h0, MEVP_IDX_INT_SRC};
    assign sleep_oversample_setting = mag_control_three[MEVP_OS_LSB +: 3];
    assign vecm_ths = {ths_msb[6:0], ths_lsb};

    // Offset applied only outside raw mode; wraps rather than saturates
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (mag_control_three[MEVP_RAW_BIT]) begin
                next_out[i] = raw[i];
            end else begin
                next_out[i] = raw[i] + off[i];
            end
        end
    end

    // Output sample registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mag_x <= '0;
            mag_y <= '0;
            mag_z <= '0;
            mag_valid <= 1'b0;
        end else begin
            mag_valid <= sample_valid;
            if (sample_valid) begin
                mag_x <= next_out[0];
                mag_y <= next_out[1];
                mag_z <= next_out[2];
            end
        end
    end

    // Ratio doubles per setting step from setting 1 up, halves or quarters per faster rate code, floored at 2
    assign os_sel = auto_sleep ? sleep_oversample_setting : wake_oversample_setting;
    always_comb begin
        logic [3:0] sh;
        logic [3:0] rate_sh;
        sh = 4'h0;
        rate_sh = 4'h0;
        case (output_data_rate)
            3'h0: rate_sh = 4'h0;
            3'h1: rate_sh = 4'h2;
            3'h2: rate_sh = 4'h3;
            3'h3: rate_sh = 4'h5;
            3'h4: rate_sh = 4'h6;
            3'h5: rate_sh = 4'h7;
            3'h6: rate_sh = 4'h8;
            default: rate_sh = 4'h9;
        endcase
        // Setting 0 shares setting 1's ratio; no setting goes below the floor
        sh = rate_sh + (os_sel == 3'h0 ? 4'h6 : 4'h7 - {1'b0, os_sel});
        if (output_data_rate == MEVP_RATE_800 || sh >= 4'h9) begin
            oversampling_ratio = MEVP_RATIO_FLOOR;
        end else begin
            oversampling_ratio = MEVP_RATIO_TOP >> sh;
        end
    end

    // Threshold reference refresh strobe to the threshold detector
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ths_ref_load <= 3'h0;
        end else if (ths_event) begin
            ths_ref_load <= mag_control_three[MEVP_THS_UPD_BIT] ? ths_axis : 3'h7;
        end else begin
            ths_ref_load <= 3'h0;
        end
    end

    // Squared distance; zero references give absolute magnitude
    always_comb begin
        logic signed [SW:0] d;
        logic signed [2*SW+1:0] sq;
        dist2 = '0;
        d = '0;
        sq = '0;
        for (int i = 0; i < 3; i++) begin
            d = (SW+1)'(mag_x) - (SW+1)'(vref[i]);
            if (i == 1) d = (SW+1)'(mag_y) - (SW+1)'(vref[i]);
            if (i == 2) d = (SW+1)'(mag_z) - (SW+1)'(vref[i]);
            // Square at full width so no difference wraps before the sum
            sq = (2*SW+2)'(d) * (2*SW+2)'(d);
            dist2 = dist2 + (2*SW+4)'(unsigned'(sq));
        end
    end
    assign ths2 = 32'(vecm_ths) * 32'(vecm_ths);
    assign over = (2*SW+4)'(ths2) < dist2;
    assign vecm_fire = over && dbc >= vecm_cnt;

    // Debounce counts one per output sample
    // Disabling the detector zeroes the count, so each enable starts afresh
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dbc <= 8'h00;
        end else if (!mag_vector_change_config[MEVP_EN_BIT]) begin
            dbc <= 8'h00;
        end else if (mag_valid) begin
            if (over) begin
                if (dbc != 8'hff) dbc <= dbc + 8'h01;
            end else if (ths_msb[MEVP_DBCNTM_BIT]) begin
                dbc <= 8'h00;
            end else if (dbc != 8'h00) begin
                dbc <= dbc - 8'h01;
            end
        end
    end

    // Internal references, not on the read path
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            en_d <= 1'b0;
            for (int i = 0; i < 3; i++) vref[i] <= '0;
        end else begin
            en_d <= mag_vector_change_config[MEVP_EN_BIT];
            if (mag_vector_change_config[MEVP_EN_BIT] && !en_d) begin
                vref[0] <= mag_vector_change_config[MEVP_INITM_BIT] ? init_ref[0] : mag_x;
                vref[1] <= mag_vector_change_config[MEVP_INITM_BIT] ? init_ref[1] : mag_y;
                vref[2] <= mag_vector_change_config[MEVP_INITM_BIT] ? init_ref[2] : mag_z;
            end else if (mag_valid && vecm_fire && !mag_vector_change_config[MEVP_UPDM_BIT]) begin
                vref[0] <= mag_x;
                vref[1] <= mag_y;
                vref[2] <= mag_z;
            end else if (mag_vector_change_config[MEVP_INITM_BIT] && mag_vector_change_config[MEVP_UPDM_BIT]) begin
                for (int i = 0; i < 3; i++) vref[i] <= init_ref[i]; // Live manual references
            end
        end
    end

    // Live vector state, recomputed each sample
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vecm_live <= 1'b0;
        end else if (!mag_vector_change_config[MEVP_EN_BIT]) begin
            vecm_live <= 1'b0;
        end else if (mag_valid) begin
            vecm_live <= vecm_fire;
        end
    end

    // Source flags; a set beats the clearing read
    // A non-latched vector flag ignores the read and tracks the live state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mag_interrupt_source <= MEVP_RESET_VALUE;
        end else begin
            mag_interrupt_source[7:3] <= 5'h00;
            if (ths_event) begin
                mag_interrupt_source[MEVP_SRC_THS_BIT] <= 1'b1;
            end else if (src_read) begin
                mag_interrupt_source[MEVP_SRC_THS_BIT] <= 1'b0;
            end
            if (sample_valid) begin
                mag_interrupt_source[MEVP_SRC_DRDY_BIT] <= 1'b1;
            end else if (src_read) begin
                mag_interrupt_source[MEVP_SRC_DRDY_BIT] <= 1'b0;
            end
            if (!mag_vector_change_config[MEVP_ELE_BIT]) begin
                mag_interrupt_source[MEVP_SRC_VECM_BIT] <= vecm_live;
            end else if (mag_valid && vecm_fire && mag_vector_change_config[MEVP_EN_BIT]) begin
                mag_interrupt_source[MEVP_SRC_VECM_BIT] <= 1'b1;
            end else if (src_read) begin
                mag_interrupt_source[MEVP_SRC_VECM_BIT] <= 1'b0;
            end
        end
    end

    // Register writes
    // Unmapped words, including aliases above index 0xff, are dropped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mag_control_three <= MEVP_RESET_VALUE;
            mag_vector_change_config <= MEVP_RESET_VALUE;
            ths_msb <= MEVP_RESET_VALUE;
            ths_lsb <= MEVP_RESET_VALUE;
            vecm_cnt <= MEVP_RESET_VALUE;
            for (int i = 0; i < 3; i++) begin
                off[i] <= '0;
                init_ref[i] <= '0;
            end
        end else if (wr_en && idx[9:8] == 2'h0) begin
            case (idx[7:0])
                MEVP_IDX_CTRL3: mag_control_three <= pwdata[7:0];
                MEVP_IDX_VECM_CFG: mag_vector_change_config <= pwdata[7:0];
                MEVP_IDX_VECM_THS_MSB: ths_msb <= pwdata[7:0];
                MEVP_IDX_VECM_THS_LSB: ths_lsb <= pwdata[7:0];
                MEVP_IDX_VECM_CNT: vecm_cnt <= pwdata[7:0];
                MEVP_IDX_OFF_X: off[0] <= pwdata[SW-1:0];
                MEVP_IDX_OFF_Y: off[1] <= pwdata[SW-1:0];
                MEVP_IDX_OFF_Z: off[2] <= pwdata[SW-1:0];
                MEVP_IDX_INIT_X: init_ref[0] <= pwdata[SW-1:0];
                MEVP_IDX_INIT_Y: init_ref[1] <= pwdata[SW-1:0];
                MEVP_IDX_INIT_Z: init_ref[2] <= pwdata[SW-1:0];
                default: ;
            endcase
        end
    end

    // Read mux; internal references are deliberately absent
    always_comb begin
        prdata = 32'h0000_0000;
        if (idx[9:8] == 2'h0) begin
            case (idx[7:0])
                MEVP_IDX_CTRL3: prdata = {24'h0, mag_control_three};
                MEVP_IDX_INT_SRC: prdata = {24'h0, mag_interrupt_source};
                MEVP_IDX_VECM_CFG: prdata = {24'h0, mag_vector_change_config};
                MEVP_IDX_VECM_THS_MSB: prdata = {24'h0, ths_msb};
                MEVP_IDX_VECM_THS_LSB: prdata = {24'h0, ths_lsb};
                MEVP_IDX_VECM_CNT: prdata = {24'h0, vecm_cnt};
                MEVP_IDX_OFF_X: prdata = 32'(unsigned'(off[0]));
                MEVP_IDX_OFF_Y: prdata = 32'(unsigned'(off[1]));
                MEVP_IDX_OFF_Z: prdata = 32'(unsigned'(off[2]));
                MEVP_IDX_INIT_X: prdata = 32'(unsigned'(init_ref[0]));
                MEVP_IDX_INIT_Y: prdata = 32'(unsigned'(init_ref[1]));
                MEVP_IDX_INIT_Z: prdata = 32'(unsigned'(init_ref[2]));
                MEVP_IDX_STATUS: prdata = {24'h0, dbc};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule : mevp_postproc

// ==== tb/mevp_post_monitor.sv ====
`timescale 1ns/1ns
module mevp_post_monitor
    import mevp_pkg::*;
#(
    parameter int SW = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic sample_valid,
    input wire logic signed [SW-1:0] raw_x,
    input wire logic signed [SW-1:0] mag_x,
    input wire logic mag_valid,
    input wire logic [2:0] output_data_rate,
    input wire logic auto_sleep,
    input wire logic ths_event,
    input wire logic [2:0] ths_axis,
    input wire logic [10:0] oversampling_ratio,
    input wire logic [2:0] ths_ref_load
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic raw_sel;
    logic upd_sel;
    logic [2:0] os_sel;
    // Shadow of the control fields, since the checker cannot see registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) {raw_sel, os_sel, upd_sel} <= 5'h00;
        else if (psel && penable && pwrite && paddr == {2'b00, MEVP_IDX_CTRL3, 2'b00}) {raw_sel, os_sel, upd_sel} <= pwdata[7:3];
    end
    sequence s_src_rd;
        psel && penable && !pwrite && paddr == {2'b00, MEVP_IDX_INT_SRC, 2'b00};
    endsequence
    sequence s_ths_all;
        ths_event && !upd_sel;
    endsequence
    property p_mag_valid; sample_valid |=> mag_valid; endproperty
    a_mag_valid: assert property (p_mag_valid) else $error("no output pulse");
    property p_mag_quiet; !sample_valid |=> !mag_valid; endproperty
    a_mag_quiet: assert property (p_mag_quiet) else $error("spurious output pulse");
    property p_raw_out; sample_valid && raw_sel |=> mag_x == $past(raw_x); endproperty
    a_raw_out: assert property (p_raw_out) else $error("raw sample altered");
    property p_ref_all; s_ths_all |=> ths_ref_load == 3'h7; endproperty
    a_ref_all: assert property (p_ref_all) else $error("not all references refreshed");
    property p_ref_axis; ths_event && upd_sel |=> ths_ref_load == $past(ths_axis); endproperty
    a_ref_axis: assert property (p_ref_axis) else $error("wrong axis refreshed");
    property p_ref_idle; !ths_event |=> ths_ref_load == 3'h0; endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh without event");
    property p_ratio_fast;
        output_data_rate == MEVP_RATE_800 |-> oversampling_ratio == MEVP_RATIO_FLOOR;
    endproperty
    a_ratio_fast: assert property (p_ratio_fast) else $error("fast rate ratio wrong");
    property p_ratio_sleep;
        auto_sleep && os_sel == 3'h7 && output_data_rate == MEVP_RATE_1P56
            |-> oversampling_ratio == MEVP_RATIO_TOP;
    endproperty
    a_ratio_sleep: assert property (p_ratio_sleep) else $error("sleep ratio wrong");
    property p_src_upper; s_src_rd |-> prdata[31:3] == 29'h0; endproperty
    a_src_upper: assert property (p_src_upper) else $error("source upper bits set");
endmodule : mevp_post_monitor

bind mevp_postproc mevp_post_monitor #(.SW(SW)) i_mevp_post_monitor (.mclk(mclk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .sample_valid(sample_valid), .raw_x(raw_x), .mag_x(mag_x), .mag_valid(mag_valid),
    .output_data_rate(output_data_rate), .auto_sleep(auto_sleep), .ths_event(ths_event),
    .ths_axis(ths_axis), .oversampling_ratio(oversampling_ratio), .ths_ref_load(ths_ref_load));

// ==== tb/mevp_front_model.sv ====
`timescale 1ns/1ns
module mevp_front_model #(
    parameter int SW = 16
) (
    input wire logic mclk,
    output logic sample_valid,
    output logic signed [SW-1:0] raw_x,
    output logic signed [SW-1:0] raw_y,
    output logic signed [SW-1:0] raw_z,
    output logic ths_event,
    output logic [2:0] ths_axis
);
    // Quiet front end at time zero
    initial begin
        {sample_valid, ths_event, ths_axis} = 5'h00;
        {raw_x, raw_y, raw_z} = '0;
    end
    // One-cycle sample; lines then invert so stale data never looks valid
    task send_sample(input logic signed [SW-1:0] x, input logic signed [SW-1:0] y, input logic signed [SW-1:0] z);
        @(posedge mclk);
        sample_valid <= 1'b1;
        raw_x <= x;
        raw_y <= y;
        raw_z <= z;
        @(posedge mclk);
        sample_valid <= 1'b0;
        raw_x <= ~x;
        raw_y <= ~y;
        raw_z <= ~z;
    endtask : send_sample
    // Threshold detector pulse with the one-hot axes that fired
    task send_ths(input logic [2:0] a);
        @(posedge mclk);
        ths_event <= 1'b1;
        ths_axis <= a;
        @(posedge mclk);
        ths_event <= 1'b0;
        ths_axis <= ~a;
    endtask : send_ths
endmodule : mevp_front_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
    import mevp_pkg::*;
    logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, sample_valid, mag_valid, auto_sleep, ths_event;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic signed [15:0] raw_x, raw_y, raw_z, mag_x, mag_y, mag_z;
    logic [2:0] output_data_rate, wake_oversample_setting, ths_axis, ths_ref_load;
    logic [10:0] oversampling_ratio;
    logic err;
    int fail_count = 0;
    int total_checks = 0;
    mevp_postproc #(.SW(16)) i_mevp_postproc (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z),
        .output_data_rate(output_data_rate), .auto_sleep(auto_sleep), .wake_oversample_setting(wake_oversample_setting),
        .ths_event(ths_event), .ths_axis(ths_axis), .mag_x(mag_x), .mag_y(mag_y), .mag_z(mag_z),
        .mag_valid(mag_valid), .oversampling_ratio(oversampling_ratio), .ths_ref_load(ths_ref_load));
    mevp_front_model #(.SW(16)) i_mevp_front_model (.mclk(mclk), .sample_valid(sample_valid), .raw_x(raw_x),
        .raw_y(raw_y), .raw_z(raw_z), .ths_event(ths_event), .ths_axis(ths_axis));
    // Free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task end_sim;
        if (fail_count == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Full APB cycle; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd_chk(input logic [7:0] i, input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        chk(r, e);
    endtask : rd_chk
    task ratio_chk(input logic sl, input logic [2:0] o, input logic [10:0] e);
        @(posedge mclk);
        auto_sleep <= sl;
        output_data_rate <= o;
        @(posedge mclk);
        #1 chk({21'h0, oversampling_ratio}, {21'h0, e});
    endtask : ratio_chk
    // A hang ends the run as a failure; normal run is under two hundred cycles
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, auto_sleep} = 5'h00;
        {paddr, pwdata, output_data_rate} = '0;
        wake_oversample_setting = 3'h7;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd_chk(MEVP_IDX_INT_SRC, 32'h0);
        rd_chk(MEVP_IDX_VECM_CFG, 32'h0);
        rd_chk(8'h50, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, MEVP_IDX_OFF_X, 32'h5);
        apb(1'b1, MEVP_IDX_OFF_Z, 32'hfffe);
        apb(1'b1, MEVP_IDX_CTRL3, 32'h0);
        i_mevp_front_model.send_sample(16'sd100, 16'sd7, 16'sd9);
        #1 chk({16'h0, mag_x}, 32'd105);
        chk({16'h0, mag_y}, 32'd7);
        chk({16'h0, mag_z}, 32'd7);
        apb(1'b1, MEVP_IDX_CTRL3, 32'h80);
        i_mevp_front_model.send_sample(16'sd100, 16'sd7, 16'sd9);
        #1 chk({16'h0, mag_x}, 32'd100);
        chk({16'h0, mag_z}, 32'd9);
        rd_chk(MEVP_IDX_INT_SRC, 32'h1);
        rd_chk(MEVP_IDX_INT_SRC, 32'h0);
        apb(1'b1, MEVP_IDX_CTRL3, 32'h0);
        i_mevp_front_model.send_ths(3'b010);
        #1 chk({29'h0, ths_ref_load}, 32'h7);
        rd_chk(MEVP_IDX_INT_SRC, 32'h4);
        rd_chk(MEVP_IDX_INT_SRC, 32'h0);
        apb(1'b1, MEVP_IDX_CTRL3, 32'h08);
        i_mevp_front_model.send_ths(3'b100);
        #1 chk({29'h0, ths_ref_load}, 32'h4);
        rd_chk(MEVP_IDX_INT_SRC, 32'h4);
        apb(1'b1, MEVP_IDX_CTRL3, 32'h70);
        ratio_chk(1'b1, 3'h0, 11'h400);
        ratio_chk(1'b1, 3'h7, 11'h002);
        apb(1'b1, MEVP_IDX_CTRL3, 32'h20);
        ratio_chk(1'b1, 3'h1, 11'h008);
        ratio_chk(1'b0, 3'h0, 11'h400);
        // Setting 0 must give the same ratio as setting 1
        apb(1'b1, MEVP_IDX_CTRL3, 32'h0);
        ratio_chk(1'b1, 3'h0, 11'h010);
        // Zero references from init registers, so absolute magnitude is tested
        apb(1'b1, MEVP_IDX_VECM_THS_LSB, 32'h10);
        apb(1'b1, MEVP_IDX_VECM_CNT, 32'h0);
        apb(1'b1, MEVP_IDX_VECM_CFG, 32'h68);
        rd_chk(MEVP_IDX_VECM_CFG, 32'h68);
        i_mevp_front_model.send_sample(16'sd5, 16'sd0, 16'sd0);
        rd_chk(MEVP_IDX_INT_SRC, 32'h1);
        i_mevp_front_model.send_sample(16'sd100, 16'sd0, 16'sd0);
        repeat (5) @(posedge mclk);
        rd_chk(MEVP_IDX_INT_SRC, 32'h3);
        rd_chk(MEVP_IDX_INT_SRC, 32'h0);
        rd_chk(MEVP_IDX_STATUS, 32'h1);
        rd_chk(8'h77, 32'h0);
        // Unlatched, references from the output, none refreshed on event, debounce of one
        apb(1'b1, MEVP_IDX_VECM_CFG, 32'h0);
        apb(1'b1, MEVP_IDX_VECM_CNT, 32'h1);
        apb(1'b1, MEVP_IDX_VECM_CFG, 32'h18);
        i_mevp_front_model.send_sample(16'sd100, 16'sd0, 16'sd0);
        i_mevp_front_model.send_sample(16'sd200, 16'sd0, 16'sd0);
        i_mevp_front_model.send_sample(16'sd200, 16'sd0, 16'sd0);
        rd_chk(MEVP_IDX_INT_SRC, 32'h3);
        rd_chk(MEVP_IDX_INT_SRC, 32'h2);
        i_mevp_front_model.send_sample(16'sd100, 16'sd0, 16'sd0);
        rd_chk(MEVP_IDX_INT_SRC, 32'h1);
        end_sim();
    end
endmodule : tb_top
